// [logic/tiop_map.svh]
// constant map of the timed i/o port: field positions, reset values, timing
`ifndef TIOP_MAP_SVH
`define TIOP_MAP_SVH

// ----------------------------------------------------------------
// clock blocks and counter
// ----------------------------------------------------------------
`define TIOP_NUM_CLKBLK 6
`define TIOP_CLKSEL_W 3
`define TIOP_CNT_W 16
`define TIOP_DIV_W 8
`define TIOP_MCLK_PERIOD_NS 10
`define TIOP_REF_PERIOD_NS 10
`define TIOP_REF_DIV (`TIOP_REF_PERIOD_NS / `TIOP_MCLK_PERIOD_NS - 1)

// ----------------------------------------------------------------
// fields of the port configuration word
// ----------------------------------------------------------------
`define TIOP_CFG_DIR 0
`define TIOP_CFG_CLK_LSB 1
`define TIOP_CFG_COND_LSB 4
`define TIOP_CFG_STB 6

// ----------------------------------------------------------------
// fields of the clock block configuration word
// ----------------------------------------------------------------
`define TIOP_CB_IDX_LSB 0
`define TIOP_CB_EXT 3
`define TIOP_CB_DIV_LSB 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TIOP_RST_CLKSEL 3'h0
`define TIOP_RST_DIV 8'h00

`endif

// [logic/tiop_pkg.sv]
// types shared by the timed i/o port files
package tiop_pkg;

	// processor operations on the port
	typedef enum logic [2:0] {
		OP_CLKBLK = 3'h0,
		OP_OUT = 3'h1,
		OP_IN = 3'h2,
		OP_CONFIG = 3'h3,
		OP_COND = 3'h4,
		OP_TIME = 3'h5,
		OP_COUNT = 3'h6,
		OP_STAMP = 3'h7
	} tiop_op_type;

	// pin condition that an input waits for
	typedef enum logic [1:0] {
		COND_NONE = 2'h0,
		COND_EQ = 2'h1,
		COND_NEQ = 2'h2
	} tiop_cond_type;

endpackage

// [logic/tiop_clock_block.sv]
// one programmable clock block: divided reference or external pin edges
`timescale 1ns/1ps
`default_nettype none
`include "tiop_map.svh"

module tiop_clock_block import tiop_pkg::*; #(
	parameter bit FIXED_REF = 1'b0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// configuration
	input wire logic cfgWrite,
	input wire logic cfgExt,
	input wire logic [`TIOP_DIV_W-1:0] cfgDiv,
	// synchronised rising edge of the 1-bit clock port
	input wire logic extEdge,
	// port rate tick
	output logic tick
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [`TIOP_DIV_W-1:0] div_q, div_d; // cycles per tick minus one
	logic [`TIOP_DIV_W-1:0] cnt_q, cnt_d; // divider count
	logic ext_q, ext_d; // external pin is the source
	logic tick_q, tick_d; // registered tick

	// next values: block 0 is locked to the reference rate
	always_comb begin
		div_d = div_q;
		ext_d = ext_q;
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (cfgWrite && !FIXED_REF) begin
			div_d = cfgDiv;
			ext_d = cfgExt;
		end
		if (FIXED_REF) begin
			div_d = `TIOP_DIV_W'(`TIOP_REF_DIV);
			ext_d = 1'b0;
		end
		if (ext_q) begin
			tick_d = extEdge;
			cnt_d = '0;
		end else if (cnt_q >= div_q) begin
			tick_d = 1'b1;
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + `TIOP_DIV_W'(1);
		end
	end

	// registers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			div_q <= `TIOP_RST_DIV;
			ext_q <= 1'b0;
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			ext_q <= ext_d;
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_ext_tick_edge: assert property (@(posedge mclk) disable iff (reset)
		ext_q |=> (tick_q == $past(extEdge)))
		else $error("external clock tick does not follow pin edge");

endmodule
`default_nettype wire

// [logic/tiop_port.sv]
// timed i/o port with counter, timestamps, conditions, strobes and clock blocks
`timescale 1ns/1ps
`default_nettype none
`include "tiop_map.svh"

module tiop_port import tiop_pkg::*; #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// processor side
	input wire logic cpuValid,
	input wire tiop_op_type cpuOp,
	input wire logic [31:0] cpuWdata,
	output logic cpuAck,
	output logic [31:0] cpuRdata,
	output logic cpuHasData,
	// tile pin multiplexing, same clock domain
	input wire logic linkEnable,
	input wire logic [WIDTH-1:0] narrowOwn,
	// device pins
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut,
	output logic [WIDTH-1:0] pinOeN,
	input wire logic strobeIn,
	output logic strobeOut,
	input wire logic clkPinIn,
	// event to the owning tile
	output logic pinEvent
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] pinMeta_q, pinSync_q; // pin data, two stages
	logic stbMeta_q, stbSync_q; // strobe in, two stages
	logic ckMeta_q, ckSync_q, ckPrev_q; // clock pin, two stages and history
	logic extEdge; // rising edge of the clock pin

	// two flops before any logic looks at a pin
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pinMeta_q <= '0;
			pinSync_q <= '0;
			stbMeta_q <= 1'b0;
			stbSync_q <= 1'b0;
			ckMeta_q <= 1'b0;
			ckSync_q <= 1'b0;
			ckPrev_q <= 1'b0;
		end else begin
			pinMeta_q <= pinIn;
			pinSync_q <= pinMeta_q;
			stbMeta_q <= strobeIn;
			stbSync_q <= stbMeta_q;
			ckMeta_q <= clkPinIn;
			ckSync_q <= ckMeta_q;
			ckPrev_q <= ckSync_q;
		end
	end

	assign extEdge = ckSync_q & ~ckPrev_q;

	// ----------------------------------------------------------------
	// clock blocks
	// ----------------------------------------------------------------
	logic [`TIOP_NUM_CLKBLK-1:0] tickVec; // one tick per block
	logic cbWrite; // clock block configuration write
	logic [`TIOP_CLKSEL_W-1:0] cbIdx; // addressed block

	assign cbWrite = cpuValid && (cpuOp == OP_CLKBLK);
	assign cbIdx = cpuWdata[`TIOP_CB_IDX_LSB +: `TIOP_CLKSEL_W];

	// six blocks, the first locked to the reference clock
	for (genvar b = 0; b < `TIOP_NUM_CLKBLK; b++) begin : g_cb
		tiop_clock_block #(.FIXED_REF(b == 0)) u_cb (
			.mclk(mclk),
			.reset(reset),
			.cfgWrite(cbWrite && (cbIdx == `TIOP_CLKSEL_W'(b))),
			.cfgExt(cpuWdata[`TIOP_CB_EXT]),
			.cfgDiv(cpuWdata[`TIOP_CB_DIV_LSB +: `TIOP_DIV_W]),
			.extEdge(extEdge),
			.tick(tickVec[b])
		);
	end

	// ----------------------------------------------------------------
	// port state
	// ----------------------------------------------------------------
	logic dirOut_q, dirOut_d; // whole port drives, never mixed
	logic [`TIOP_CLKSEL_W-1:0] clkSel_q, clkSel_d; // clock block in use
	tiop_cond_type cond_q, cond_d; // pin condition mode
	logic [WIDTH-1:0] condVal_q, condVal_d; // condition compare value
	logic stbEn_q, stbEn_d; // strobes in use
	logic [WIDTH-1:0] xfer_q, xfer_d; // transfer register
	logic xferFull_q, xferFull_d; // transfer register holds data
	logic [`TIOP_CNT_W-1:0] count_q, count_d; // port counter
	logic [`TIOP_CNT_W-1:0] time_q, time_d; // deferred transfer count
	logic timed_q, timed_d; // transfer waits for time_q
	logic [`TIOP_CNT_W-1:0] stamp_q, stamp_d; // last transfer count
	logic [WIDTH-1:0] pinOut_q, pinOut_d; // serializer output stage
	logic [WIDTH-1:0] pinOeN_q, pinOeN_d; // low where the port drives
	logic strobeOut_q, strobeOut_d; // outgoing strobe
	logic event_q, event_d; // condition event pulse
	logic ack_q; // operation done
	logic [31:0] rdata_q, rdata_d; // read data
	logic hasData_q, hasData_d; // read carried fresh input

	logic portTick; // selected port clock tick
	logic timeOk; // counter reached deferred time
	logic condOk; // pins meet the condition
	logic stbOk; // strobe qualifies the sample
	logic outFire; // output word moves to the pins
	logic inFire; // pins move into the transfer register

	assign portTick = tickVec[clkSel_q];
	assign timeOk = !timed_q || (count_q == time_q);
	assign condOk = (cond_q == COND_NONE) ||
		((cond_q == COND_EQ) && (pinSync_q == condVal_q)) ||
		((cond_q == COND_NEQ) && (pinSync_q != condVal_q));
	assign stbOk = !stbEn_q || stbSync_q;
	assign outFire = dirOut_q && portTick && xferFull_q && timeOk;
	assign inFire = !dirOut_q && portTick && timeOk && condOk && stbOk;

	// next values; processor first, pin side last so a capture wins
	always_comb begin
		dirOut_d = dirOut_q;
		clkSel_d = clkSel_q;
		cond_d = cond_q;
		condVal_d = condVal_q;
		stbEn_d = stbEn_q;
		xfer_d = xfer_q;
		xferFull_d = xferFull_q;
		count_d = count_q;
		time_d = time_q;
		timed_d = timed_q;
		stamp_d = stamp_q;
		pinOut_d = pinOut_q;
		strobeOut_d = strobeOut_q;
		event_d = 1'b0;
		rdata_d = '0;
		hasData_d = 1'b0;
		// every operation answers on the next edge
		if (cpuValid) begin
			case (cpuOp)
				OP_OUT: begin
					xfer_d = cpuWdata[WIDTH-1:0];
					xferFull_d = 1'b1;
				end
				OP_IN: begin
					rdata_d = 32'(xfer_q);
					hasData_d = xferFull_q;
					xferFull_d = 1'b0;
				end
				OP_CONFIG: begin
					dirOut_d = cpuWdata[`TIOP_CFG_DIR];
					if (cpuWdata[`TIOP_CFG_CLK_LSB +: `TIOP_CLKSEL_W] < `TIOP_CLKSEL_W'(`TIOP_NUM_CLKBLK))
						clkSel_d = cpuWdata[`TIOP_CFG_CLK_LSB +: `TIOP_CLKSEL_W];
					cond_d = tiop_cond_type'(cpuWdata[`TIOP_CFG_COND_LSB +: 2]);
					stbEn_d = cpuWdata[`TIOP_CFG_STB];
				end
				OP_COND: condVal_d = cpuWdata[WIDTH-1:0];
				OP_TIME: begin
					time_d = cpuWdata[`TIOP_CNT_W-1:0];
					timed_d = 1'b1;
				end
				OP_COUNT: rdata_d = 32'(count_q);
				OP_STAMP: rdata_d = 32'(stamp_q);
				default: ;
			endcase
		end
		// counter runs on the port clock
		if (portTick) begin
			count_d = count_q + `TIOP_CNT_W'(1);
			strobeOut_d = 1'b0;
		end
		// output path: transfer register into the serializer stage
		if (outFire) begin
			pinOut_d = xfer_q;
			xferFull_d = cpuValid && (cpuOp == OP_OUT); // a word written now stays queued
			strobeOut_d = stbEn_q;
			stamp_d = count_q;
			timed_d = cpuValid && (cpuOp == OP_TIME); // a fresh arm survives the fire
		end
		// input path: sampled pins into the transfer register
		if (inFire) begin
			xfer_d = pinSync_q;
			xferFull_d = 1'b1;
			stamp_d = count_q;
			timed_d = cpuValid && (cpuOp == OP_TIME); // a fresh arm survives the capture
			event_d = (cond_q != COND_NONE);
		end
		// drivers off for inputs, link owner or narrower port owner
		pinOeN_d = ~{WIDTH{dirOut_d}} | {WIDTH{linkEnable}} | narrowOwn;
	end

	// registers
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			dirOut_q <= 1'b0;
			clkSel_q <= `TIOP_RST_CLKSEL;
			cond_q <= COND_NONE;
			condVal_q <= '0;
			stbEn_q <= 1'b0;
			xfer_q <= '0;
			xferFull_q <= 1'b0;
			count_q <= '0;
			time_q <= '0;
			timed_q <= 1'b0;
			stamp_q <= '0;
			pinOut_q <= '0;
			pinOeN_q <= '1;
			strobeOut_q <= 1'b0;
			event_q <= 1'b0;
			ack_q <= 1'b0;
			rdata_q <= '0;
			hasData_q <= 1'b0;
		end else begin
			dirOut_q <= dirOut_d;
			clkSel_q <= clkSel_d;
			cond_q <= cond_d;
			condVal_q <= condVal_d;
			stbEn_q <= stbEn_d;
			xfer_q <= xfer_d;
			xferFull_q <= xferFull_d;
			count_q <= count_d;
			time_q <= time_d;
			timed_q <= timed_d;
			stamp_q <= stamp_d;
			pinOut_q <= pinOut_d;
			pinOeN_q <= pinOeN_d;
			strobeOut_q <= strobeOut_d;
			event_q <= event_d;
			ack_q <= cpuValid;
			rdata_q <= rdata_d;
			hasData_q <= hasData_d;
		end
	end

	// outputs straight from flops
	assign cpuAck = ack_q;
	assign cpuRdata = rdata_q;
	assign cpuHasData = hasData_q;
	assign pinOut = pinOut_q;
	assign pinOeN = pinOeN_q;
	assign strobeOut = strobeOut_q;
	assign pinEvent = event_q;
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_cond_capture;
		inFire && (cond_q != COND_NONE);
	endsequence
	sequence s_out_move;
		outFire ##1 (pinOut_q == $past(xfer_q));
	endsequence

	a_op_one_cycle: assert property (@(posedge mclk) disable iff (reset)
		cpuValid |=> cpuAck) else $error("operation not answered on next edge");
	a_count_step: assert property (@(posedge mclk) disable iff (reset)
		portTick |=> (count_q == $past(count_q) + 16'h0001)) else $error("counter missed a tick");
	a_stamp_saved: assert property (@(posedge mclk) disable iff (reset)
		(outFire || inFire) |=> (stamp_q == $past(count_q))) else $error("no timestamp taken");
	a_deferred_time: assert property (@(posedge mclk) disable iff (reset)
		(outFire || inFire) |-> (!timed_q || count_q == time_q)) else $error("transfer too early");
	a_event_cond: assert property (@(posedge mclk) disable iff (reset)
		s_cond_capture |=> pinEvent) else $error("condition match raised no event");
	a_out_strobe: assert property (@(posedge mclk) disable iff (reset)
		s_out_move |-> (strobeOut_q == $past(stbEn_q))) else $error("strobe out mismatch");
	a_strobe_idle: assert property (@(posedge mclk) disable iff (reset)
		(portTick && !outFire) |=> !strobeOut_q) else $error("strobe out without data");
	a_in_strobe: assert property (@(posedge mclk) disable iff (reset)
		(!dirOut_q && stbEn_q && !stbSync_q) |=> (stamp_q == $past(stamp_q)))
		else $error("sample taken without strobe");
	a_link_off: assert property (@(posedge mclk) disable iff (reset)
		linkEnable |=> (pinOeN_q == '1)) else $error("port still drives under link");
	a_narrow_wins: assert property (@(posedge mclk) disable iff (reset)
		1'b1 |=> ((pinOeN_q & $past(narrowOwn)) == $past(narrowOwn)))
		else $error("wider port drives a shared pin");
endmodule
`default_nettype wire

// [verification/tiop_pins_model.sv]
// model of the external hardware on the port pins
`timescale 1ns/1ps
`default_nettype none

module tiop_pins_model #(
	parameter int W = 8
) (
	// clock
	input wire logic mclk,
	// pins towards the port
	output logic [W-1:0] pinIn,
	output logic strobeIn,
	output logic clkPinIn
);
	// idle: no strobe, application clock parked low
	initial begin
		pinIn = '0;
		strobeIn = 1'b0;
		clkPinIn = 1'b0;
	end

	// --------------------------------
	// pin stimulus
	// --------------------------------
	// data and its qualifying strobe change together after an edge
	task automatic present(input logic [W-1:0] v, input logic stb);
		@(posedge mclk);
		pinIn <= v;
		strobeIn <= stb;
	endtask

	// application clock runs only for n rising edges, then stands low
	task automatic clockEdges(input int n);
		repeat (n) begin
			repeat (4) @(posedge mclk);
			clkPinIn <= 1'b1;
			repeat (4) @(posedge mclk);
			clkPinIn <= 1'b0;
		end
	endtask
endmodule

`default_nettype wire

// [verification/timed_io_port_clocking_tb.sv]
// self-checking testbench of the timed i/o port
`timescale 1ns/1ps
`default_nettype none

module timed_io_port_clocking_tb import tiop_pkg::*;;
	// clock, reset and processor side
	logic mclk, reset, cpuValid, cpuAck, cpuHasData;
	tiop_op_type cpuOp;
	logic [31:0] cpuWdata, cpuRdata, rd;
	logic hd, linkEnable, strobeIn, strobeOut, clkPinIn, pinEvent;
	// pins
	logic [7:0] narrowOwn, pinIn, pinOut, pinOeN;
	int mismatches = 0;
	int cmp_count = 0;

	tiop_port #(.WIDTH(8)) tiop_port_inst (.mclk(mclk), .reset(reset),
		.cpuValid(cpuValid), .cpuOp(cpuOp), .cpuWdata(cpuWdata), .cpuAck(cpuAck),
		.cpuRdata(cpuRdata), .cpuHasData(cpuHasData), .linkEnable(linkEnable),
		.narrowOwn(narrowOwn), .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN),
		.strobeIn(strobeIn), .strobeOut(strobeOut), .clkPinIn(clkPinIn),
		.pinEvent(pinEvent));

	tiop_pins_model #(.W(8)) tiop_pins_model_inst (.mclk(mclk), .pinIn(pinIn),
		.strobeIn(strobeIn), .clkPinIn(clkPinIn));

	// --------------------------------
	// shared tasks
	// --------------------------------
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one processor operation; answer must come one edge later
	task automatic op(input tiop_op_type o, input logic [31:0] w);
		@(posedge mclk);
		cpuValid <= 1'b1;
		cpuOp <= o;
		cpuWdata <= w;
		@(posedge mclk);
		cpuValid <= 1'b0;
		#1;
		chk({31'h0, cpuAck}, 32'h1);
		rd = cpuRdata;
		hd = cpuHasData;
	endtask

	// settle n edges, look just after the last
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// verdict
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// --------------------------------
	// scenarios
	// --------------------------------
	// reset state, input direction on block 0 counting every edge
	task automatic t_reset();
		logic [15:0] k;
		chk({24'h0, pinOeN}, 32'hff);
		chk({31'h0, strobeOut}, 32'h0);
		op(OP_COUNT, 32'h0);
		k = rd[15:0];
		op(OP_COUNT, 32'h0);
		chk(rd, {16'h0, k + 16'h2});
	endtask

	// strobed output, one-cycle strobe, timestamp of the transfer
	task automatic t_out();
		logic [15:0] k;
		op(OP_CONFIG, 32'h41);
		cyc(3);
		chk({24'h0, pinOeN}, 32'h0);
		op(OP_COUNT, 32'h0);
		k = rd[15:0];
		op(OP_OUT, 32'hffff_ffa5);
		cyc(1);
		chk({24'h0, pinOut}, 32'ha5);
		chk({31'h0, strobeOut}, 32'h1);
		cyc(1);
		chk({31'h0, strobeOut}, 32'h0);
		op(OP_STAMP, 32'h0);
		chk(rd, {16'h0, k + 16'h3});
	endtask

	// pin sharing with narrower port and link
	task automatic t_share();
		@(posedge mclk);
		narrowOwn <= 8'h0f;
		cyc(3);
		chk({24'h0, pinOeN}, 32'h0f);
		chk({24'h0, pinOut}, 32'ha5);
		@(posedge mclk);
		linkEnable <= 1'b1;
		cyc(3);
		chk({24'h0, pinOeN}, 32'hff);
		@(posedge mclk);
		linkEnable <= 1'b0;
		narrowOwn <= 8'h00;
		cyc(3);
		chk({24'h0, pinOeN}, 32'h0);
	endtask

	// output deferred to a future count
	task automatic t_timed();
		logic [15:0] k;
		int n;
		op(OP_COUNT, 32'h0);
		k = rd[15:0];
		op(OP_TIME, {16'h0, k + 16'h10});
		op(OP_OUT, 32'h5a);
		cyc(4);
		chk({24'h0, pinOut}, 32'ha5);
		n = 0;
		while (pinOut !== 8'h5a && n < 30) begin
			cyc(1);
			n++;
		end
		chk({24'h0, pinOut}, 32'h5a);
		chk(n, 8);
		op(OP_STAMP, 32'h0);
		chk(rd, {16'h0, k + 16'h10});
	endtask

	// strobed input: unqualified data is not taken
	task automatic t_in();
		tiop_pins_model_inst.present(8'h11, 1'b0);
		op(OP_CONFIG, 32'h40);
		cyc(4);
		op(OP_IN, 32'h0);
		cyc(6);
		op(OP_IN, 32'h0);
		chk({31'h0, hd}, 32'h0);
		tiop_pins_model_inst.present(8'h3c, 1'b1);
		cyc(6);
		op(OP_IN, 32'h0);
		chk({31'h0, hd}, 32'h1);
		chk(rd, 32'h3c);
		tiop_pins_model_inst.present(8'h00, 1'b0);
	endtask

	// equality condition raises an event only on a match
	task automatic t_event();
		int seen;
		tiop_pins_model_inst.present(8'h76, 1'b0);
		op(OP_COND, 32'h77);
		op(OP_CONFIG, 32'h10);
		seen = 0;
		repeat (8) begin
			cyc(1);
			seen += int'(pinEvent === 1'b1);
		end
		chk(seen, 32'h0);
		tiop_pins_model_inst.present(8'h77, 1'b0);
		repeat (10) begin
			cyc(1);
			seen += int'(pinEvent === 1'b1);
		end
		chk({31'h0, seen > 0}, 32'h1);
	endtask

	// clock block 1 fed from the 1-bit clock pin
	task automatic t_extclk();
		logic [15:0] a;
		op(OP_CLKBLK, 32'h9);
		op(OP_CONFIG, 32'h2);
		cyc(4);
		op(OP_COUNT, 32'h0);
		a = rd[15:0];
		tiop_pins_model_inst.clockEdges(4);
		cyc(6);
		op(OP_COUNT, 32'h0);
		chk(rd, {16'h0, a + 16'h4});
	endtask

	// reset in mid-run puts the port back on block 0
	task automatic t_rereset();
		logic [15:0] k;
		@(posedge mclk);
		reset <= 1'b1;
		cyc(2);
		chk({24'h0, pinOeN}, 32'hff);
		@(posedge mclk);
		reset <= 1'b0;
		cyc(1);
		op(OP_COUNT, 32'h0);
		k = rd[15:0];
		op(OP_COUNT, 32'h0);
		chk(rd, {16'h0, k + 16'h2});
	endtask

	// --------------------------------
	// clock, reset, sequence, watchdog
	// --------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		reset = 1'b1;
		cpuValid = 1'b0;
		cpuOp = OP_COUNT;
		cpuWdata = 32'h0;
		linkEnable = 1'b0;
		narrowOwn = 8'h00;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		cyc(1);
		t_reset();
		t_out();
		t_share();
		t_timed();
		t_in();
		t_event();
		t_extclk();
		t_rereset();
		complete_run();
	end

	// cut a hang short well beyond the expected run of about 165 cycles
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
endmodule

`default_nettype wire
